// [logic/adc_ctrl_pkg.sv]
package adc_ctrl_pkg;

    // ****************************************
    // channel and coefficient set counts
    // ****************************************
    localparam int NUM_CHAN = 7;
    localparam int NUM_SETS = 4;

    // ****************************************
    // rate generation, in conversion clock edges
    // ****************************************
    localparam logic [21:0] SLOW_BASE_DIV = 22'h04_1000; // 266,240 edges
    localparam logic [21:0] FAST_BASE_DIV = 22'h00_4100; // 16,640 edges
    localparam logic [2:0] RATE_SEL_RESET = 3'h7;
    localparam logic [2:0] MAINS_MAX_RATE = 3'h3;

    // ****************************************
    // coefficient formats and reset values
    // ****************************************
    localparam int GAIN_FRAC_BITS = 23;
    localparam logic [5:0] DIV_STEPS = 6'h30;
    localparam logic [23:0] SYS_OFFSET_RESET = 24'h00_0000;
    localparam logic [23:0] SYS_GAIN_RESET = 24'h80_0000;
    localparam logic [23:0] GAIN_TARGET_MAX = 24'hA0_0000;
    localparam logic [23:0] BG_OFFSET_FACTORY = 24'h00_0000;
    localparam logic [23:0] BG_GAIN_FACTORY = 24'h80_0000;
    localparam logic [23:0] RESULT_POS_MAX = 24'h7F_FFFF;
    localparam logic [23:0] RESULT_NEG_MAX = 24'h80_0000;
    localparam logic [23:0] GAIN_COEFF_MAX = 24'hFF_FFFF;

    // ****************************************
    // system calibration command codes
    // ****************************************
    localparam logic [1:0] CMD_IDLE = 2'h0;
    localparam logic [1:0] CMD_OFFSET = 2'h1;
    localparam logic [1:0] CMD_GAIN = 2'h3;

    typedef enum logic [1:0] {
        bg_cal_off = 2'h0,
        bg_cal_offset_correct_gain_estimate = 2'h1,
        bg_cal_full_correct = 2'h2,
        bg_cal_full_estimate = 2'h3
    } background_cal_mode_t;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_divide = 3'b010,
        st_store = 3'b100
    } proc_state_t;

    typedef struct packed {
        logic en;
        logic sel_gain;
        logic [1:0] set;
        logic [23:0] data;
    } coeff_write_t;

    typedef struct packed {
        logic valid;
        logic [23:0] offset;
        logic [23:0] gain;
    } bg_meas_t;

    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [23:0] data;
    } result_t;

endpackage : adc_ctrl_pkg

// [logic/adc_rate_cal_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

module adc_rate_cal_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter logic [21:0] SLOW_DIV = SLOW_BASE_DIV,
    parameter logic [21:0] FAST_DIV = FAST_BASE_DIV
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_conv_clk,
    input wire logic [NUM_CHAN-1:0][2:0] i_output_rate_select,
    input wire logic [2:0] i_first_chan,
    input wire logic [2:0] i_last_chan,
    input wire logic i_scan_enable,
    input wire logic [1:0] i_background_cal_mode,
    input wire logic i_fixed_amp_bg_cal_enable,
    input wire bg_meas_t i_bg_meas,
    input wire logic [23:0] i_raw_result,
    input wire coeff_write_t i_coeff_wr,
    input wire logic i_sys_cal_wr,
    input wire logic [1:0] i_sys_cal_command,
    input wire logic [6:0] i_gpio_dir,
    input wire logic [6:0] i_gpio_level,
    input wire logic [6:0] i_general_purpose_pins,
    output logic [6:0] o_general_purpose_pins,
    output logic [6:0] o_general_purpose_pins_oe_n,
    output logic [6:0] o_gpio_read,
    output logic [1:0] o_sys_cal_command,
    output logic [2:0] o_conv_chan,
    output logic o_cal_slot,
    output logic o_conv_done,
    output logic o_mains_reject,
    output result_t o_result,
    output logic [NUM_SETS-1:0][23:0] o_sys_offset_coeff,
    output logic [NUM_SETS-1:0][23:0] o_sys_gain_coeff
);
    // ****************************************
    // helpers
    // ****************************************

    // conversion length in conversion clock edges for a rate code
    function automatic logic [21:0] rate_period(input logic [2:0] code,
                                                input logic [21:0] slow,
                                                input logic [21:0] fast);
        logic [21:0] base;
        base = code[2] ? fast : slow;
        return base << (2'd3 - code[1:0]);
    endfunction : rate_period

    // clamp a wide signed value to the 24-bit two's complement range
    function automatic logic [23:0] sat24(input logic signed [49:0] v);
        return (v > 50'sh7F_FFFF) ? RESULT_POS_MAX
             : (v < -50'sh80_0000) ? RESULT_NEG_MAX : v[23:0];
    endfunction : sat24

    // ****************************************
    // reset and pin synchronisers
    // ****************************************
    logic rst_meta, rst_n, conv_meta, conv_sync, conv_prev;
    logic [6:0] gpio_meta;

    // reset release through two flops
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // conversion clock and gpio inputs through two flops
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_meta <= 1'b0;
            conv_sync <= 1'b0;
            conv_prev <= 1'b0;
            gpio_meta <= 7'h00;
            o_gpio_read <= 7'h00;
        end else begin
            conv_meta <= i_conv_clk;
            conv_sync <= conv_meta;
            conv_prev <= conv_sync;
            gpio_meta <= i_general_purpose_pins;
            o_gpio_read <= gpio_meta;
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    logic [2:0] chan, cur_rate;
    logic cal_slot, cal_run;
    logic [21:0] conv_count;
    logic [1:0] sys_cmd, set;
    wire conv_tick = conv_sync & ~conv_prev;
    wire running = i_scan_enable | cal_run;
    wire cal_write = i_sys_cal_wr & (i_sys_cal_command == CMD_OFFSET
                                     || i_sys_cal_command == CMD_GAIN);

    // per-channel rate and the length of the current slot
    assign set = chan[1:0];
    assign cur_rate = i_output_rate_select[chan];
    wire [21:0] period_now = cal_slot ? FAST_DIV
                                      : rate_period(cur_rate, SLOW_DIV, FAST_DIV);
    wire conv_end = conv_tick & running & (conv_count == period_now - 22'd1);
    wire wrap = (chan == i_last_chan) | (chan > 3'd6);
    wire insert_cal = wrap & ~cal_slot & ~i_fixed_amp_bg_cal_enable
                      & (i_background_cal_mode == bg_cal_full_correct);

    // slot counter and channel interleave
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan <= 3'h0;
            cal_slot <= 1'b0;
            conv_count <= 22'h00_0000;
        end else if (cal_write || !running) begin
            chan <= i_first_chan; // fresh conversion
            cal_slot <= 1'b0;
            conv_count <= 22'h00_0000;
        end else if (conv_end) begin
            conv_count <= 22'h00_0000;
            cal_slot <= insert_cal;
            chan <= (cal_slot || (wrap && !insert_cal)) ? i_first_chan
                    : (insert_cal ? chan : chan + 3'd1);
        end else if (conv_tick) begin
            conv_count <= conv_count + 22'd1;
        end
    end

    // ****************************************
    // background calibration coefficients
    // ****************************************
    logic [NUM_SETS-1:0][23:0] bg_off, bg_gain;
    wire bg_upd_off = i_bg_meas.valid & (i_background_cal_mode == bg_cal_full_correct
        || i_background_cal_mode == bg_cal_offset_correct_gain_estimate);
    wire bg_upd_gain = i_bg_meas.valid & (i_background_cal_mode == bg_cal_full_correct);

    // correction tracks new values, estimation holds the last ones
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bg_off <= {NUM_SETS{BG_OFFSET_FACTORY}};
            bg_gain <= {NUM_SETS{BG_GAIN_FACTORY}};
        end else begin
            if (bg_upd_off)
                bg_off[set] <= i_bg_meas.offset;
            if (bg_upd_gain)
                bg_gain[set] <= i_bg_meas.gain;
        end
    end

    // background correction of the raw code
    wire signed [24:0] bg_diff = $signed({i_raw_result[23], i_raw_result})
                                 - $signed({bg_off[set][23], bg_off[set]});
    wire signed [49:0] bg_prod = bg_diff * $signed({1'b0, bg_gain[set]});
    wire [23:0] bg_corr = (i_background_cal_mode == bg_cal_off) ? i_raw_result
                          : sat24(bg_prod >>> GAIN_FRAC_BITS);

    // system offset removal, first step of the system calibration
    wire signed [24:0] sys_diff = $signed({bg_corr[23], bg_corr})
        - $signed({o_sys_offset_coeff[set][23], o_sys_offset_coeff[set]});
    wire [24:0] sys_abs = sys_diff[24] ? 25'(-sys_diff) : 25'(sys_diff);
    wire [23:0] gain_target = (o_sys_gain_coeff[set] > GAIN_TARGET_MAX)
                              ? GAIN_TARGET_MAX : o_sys_gain_coeff[set];

    // ****************************************
    // divider and coefficient store
    // ****************************************
    proc_state_t state;
    logic [1:0] job, job_set;
    logic [2:0] job_chan;
    logic job_neg;
    logic [23:0] job_corr, divisor, rem;
    logic [47:0] quo;
    logic [5:0] steps;
    wire [24:0] trial = {rem, quo[47]};
    wire fits = trial >= {1'b0, divisor};
    wire [47:0] q_lim = 48'h7F_FFFF;
    wire [23:0] norm_out = job_neg ? ((quo > q_lim + 48'd1) ? RESULT_NEG_MAX
                                                            : 24'(-quo[23:0]))
                                   : ((quo > q_lim) ? RESULT_POS_MAX : quo[23:0]);
    wire [23:0] gain_out = (quo > 48'hFF_FFFF) ? GAIN_COEFF_MAX : quo[23:0];
    wire take = conv_end & ~cal_slot;
    wire store_cal = (state == st_store) & (job != CMD_IDLE);

    // capture a finished conversion and run a restoring divide
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_idle;
            job <= CMD_IDLE;
            job_set <= 2'h0;
            job_chan <= 3'h0;
            job_neg <= 1'b0;
            job_corr <= 24'h00_0000;
            divisor <= 24'h00_0000;
            rem <= 24'h00_0000;
            quo <= 48'h0000_0000_0000;
            steps <= 6'h00;
        end else begin
            unique case (state)
                st_idle: if (take) begin
                    state <= st_divide;
                    job <= cal_run ? sys_cmd : CMD_IDLE;
                    job_set <= set;
                    job_chan <= chan;
                    job_neg <= sys_diff[24];
                    job_corr <= bg_corr;
                    divisor <= (cal_run && sys_cmd == CMD_GAIN) ? gain_target
                                                               : o_sys_gain_coeff[set];
                    rem <= 24'h00_0000;
                    quo <= {sys_abs[24:0], 23'h00_0000};
                    steps <= 6'h00;
                end
                st_divide: begin
                    rem <= fits ? 24'(trial - {1'b0, divisor}) : trial[23:0];
                    quo <= {quo[46:0], fits};
                    steps <= steps + 6'd1;
                    if (steps == DIV_STEPS - 6'd1)
                        state <= st_store;
                end
                st_store: state <= st_idle;
            endcase
        end
    end

    // system coefficients, command and results
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_sys_offset_coeff <= {NUM_SETS{SYS_OFFSET_RESET}};
            o_sys_gain_coeff <= {NUM_SETS{SYS_GAIN_RESET}};
            sys_cmd <= CMD_IDLE;
            cal_run <= 1'b0;
            o_result <= '0;
        end else begin
            o_result.valid <= 1'b0;
            if (i_coeff_wr.en && !i_coeff_wr.sel_gain)
                o_sys_offset_coeff[i_coeff_wr.set] <= i_coeff_wr.data;
            if (i_coeff_wr.en && i_coeff_wr.sel_gain)
                o_sys_gain_coeff[i_coeff_wr.set] <= i_coeff_wr.data;
            if (store_cal && job == CMD_OFFSET)
                o_sys_offset_coeff[job_set] <= job_corr;
            if (store_cal && job == CMD_GAIN)
                o_sys_gain_coeff[job_set] <= gain_out;
            if (state == st_store && job == CMD_IDLE) begin
                o_result.valid <= 1'b1;
                o_result.chan <= job_chan;
                o_result.data <= norm_out;
            end
            if (take && cal_run)
                cal_run <= 1'b0;
            if (store_cal)
                sys_cmd <= CMD_IDLE;
            if (i_sys_cal_wr) begin
                sys_cmd <= i_sys_cal_command; // a write wins over the self clear
                cal_run <= cal_write;
            end
        end
    end

    // ****************************************
    // status and gpio outputs
    // ****************************************
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_general_purpose_pins <= 7'h00;
            o_general_purpose_pins_oe_n <= 7'h7F;
            o_mains_reject <= 1'b0;
            o_conv_done <= 1'b0;
        end else begin
            o_general_purpose_pins <= i_gpio_level & i_gpio_dir;
            o_general_purpose_pins_oe_n <= ~i_gpio_dir;
            o_mains_reject <= ~cal_slot & (cur_rate <= MAINS_MAX_RATE);
            o_conv_done <= conv_end;
        end
    end

    assign o_sys_cal_command = sys_cmd;
    assign o_conv_chan = chan;
    assign o_cal_slot = cal_slot;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!rst_n);
    a_mains_rate_flag: assert property ((!cal_slot && cur_rate <= MAINS_MAX_RATE)
        |=> o_mains_reject) else $error("mains flag missing at slow rate");
    a_mains_fast_clear: assert property ((cur_rate > MAINS_MAX_RATE)
        |=> !o_mains_reject) else $error("mains flag set at fast rate");
    a_cal_slot_cause: assert property ($rose(cal_slot) |->
        $past(i_background_cal_mode) == bg_cal_full_correct
        && !$past(i_fixed_amp_bg_cal_enable)) else $error("cal slot without mode");
    a_scan_wraps: assert property ((conv_end && !cal_write && !cal_slot && !insert_cal
        && chan == i_last_chan) |=> chan == $past(i_first_chan))
        else $error("scan did not wrap");
    a_cmd_self_exit: assert property ((store_cal && !i_sys_cal_wr)
        |=> sys_cmd == CMD_IDLE) else $error("command did not exit");
    a_offset_stored: assert property ((store_cal && job == CMD_OFFSET && !i_coeff_wr.en)
        |=> o_sys_offset_coeff[$past(job_set)] == $past(job_corr))
        else $error("offset coefficient not stored");
    a_divide_length: assert property ($rose(state == st_divide) |->
        (state == st_divide)[*8] ##41 state == st_store) else $error("divide length");
    a_result_sat: assert property ((state == st_store && job == CMD_IDLE && !job_neg
        && quo > q_lim) |=> o_result.data == RESULT_POS_MAX) else $error("no saturation");
    c_offset_cal: cover property (store_cal && job == CMD_OFFSET);
    c_gain_cal: cover property (store_cal && job == CMD_GAIN);
    c_cal_slot: cover property ($fell(cal_slot));
    c_result_out: cover property (o_result.valid);

endmodule : adc_rate_cal_ctrl

`default_nettype wire

// [tb/conv_source.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// conversion clock and filter output model
// ****************************************
module conv_source (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [23:0] i_raw_code,
    output logic o_conv_clk,
    output logic [23:0] o_raw_result
);
    logic half;

    // free running conversion clock, one rising edge every four core cycles
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            half <= 1'b0;
            o_conv_clk <= 1'b0;
        end else begin
            half <= ~half;
            if (half) begin
                o_conv_clk <= ~o_conv_clk;
            end
        end
    end

    // filter output follows the applied input code directly, with no hold across the slot
    assign o_raw_result = i_raw_code;
endmodule : conv_source

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import adc_ctrl_pkg::*;
    localparam logic [21:0] SDIV = 22'h00_0100;
    localparam logic [21:0] FDIV = 22'h00_0040;
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic conv_clk;
    logic [23:0] raw_code = 24'h00_0000;
    logic [23:0] raw_result;
    logic [NUM_CHAN-1:0][2:0] rate = '1;
    logic [2:0] first_ch = 3'h0;
    logic [2:0] last_ch = 3'h0;
    logic scan_en = 1'b0;
    logic [1:0] bg_mode = 2'h0;
    logic fa_en = 1'b1;
    bg_meas_t bg_meas = '0;
    coeff_write_t cw = '0;
    logic cal_wr = 1'b0;
    logic [1:0] cal_cmd = 2'h0;
    logic [6:0] gdir = 7'h00;
    logic [6:0] glev = 7'h00;
    logic [6:0] gpin = 7'h00;
    logic [6:0] gout, goe_n, gread;
    logic [1:0] cmd_q;
    logic [2:0] conv_chan;
    logic cal_slot, conv_done, mains_rej;
    result_t res;
    logic [NUM_SETS-1:0][23:0] offs, gains;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    // ****************************************
    // clock, partner and design
    // ****************************************
    initial begin
        forever #10 i_core_clk = ~i_core_clk;
    end

    conv_source src_u (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .i_raw_code(raw_code), .o_conv_clk(conv_clk), .o_raw_result(raw_result));

    adc_rate_cal_ctrl #(.SLOW_DIV(SDIV), .FAST_DIV(FDIV)) dut_u (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_conv_clk(conv_clk),
        .i_output_rate_select(rate), .i_first_chan(first_ch), .i_last_chan(last_ch),
        .i_scan_enable(scan_en), .i_background_cal_mode(bg_mode),
        .i_fixed_amp_bg_cal_enable(fa_en), .i_bg_meas(bg_meas), .i_raw_result(raw_result),
        .i_coeff_wr(cw), .i_sys_cal_wr(cal_wr), .i_sys_cal_command(cal_cmd),
        .i_gpio_dir(gdir), .i_gpio_level(glev), .i_general_purpose_pins(gpin),
        .o_general_purpose_pins(gout), .o_general_purpose_pins_oe_n(goe_n),
        .o_gpio_read(gread), .o_sys_cal_command(cmd_q), .o_conv_chan(conv_chan),
        .o_cal_slot(cal_slot), .o_conv_done(conv_done), .o_mains_reject(mains_rej),
        .o_result(res), .o_sys_offset_coeff(offs), .o_sys_gain_coeff(gains));

    // ****************************************
    // shared helpers
    // ****************************************
    task automatic tick;
        @(posedge i_core_clk);
        #1;
    endtask : tick

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wait_res(output int cyc);
        cyc = 0;
        do begin
            tick();
            cyc++;
        end while (res.valid !== 1'b1 && cyc < 20000);
        if (cyc >= 20000) check(48'h0, 48'h1);
    endtask : wait_res

    task automatic wr_coeff(input logic g, input logic [1:0] s, input logic [23:0] d);
        cw = '{en: 1'b1, sel_gain: g, set: s, data: d};
        tick();
        cw = '0;
        tick();
    endtask : wr_coeff

    task automatic run_cal(input logic [1:0] c);
        int n;
        cal_cmd = c;
        cal_wr = 1'b1;
        tick();
        cal_wr = 1'b0;
        tick();
        check(cmd_q, c);
        n = 0;
        while (cmd_q !== 2'h0 && n < 4000) begin
            tick();
            n++;
        end
        check(cmd_q, 2'h0);
    endtask : run_cal

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        for (int k = 0; k < NUM_SETS; k++) begin
            check(gains[k], 24'h80_0000);
            check(offs[k], 24'h00_0000);
        end
        check(goe_n, 7'h7F);
        check(cmd_q, 2'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_gpio;
        gdir = 7'h55;
        glev = 7'h7F;
        gpin = 7'h33;
        repeat (4) tick();
        check(gout, 7'h55);
        check(goe_n, 7'h2A);
        check(gread, 7'h33);
        $display("test gpio done");
    endtask : t_gpio

    task automatic t_rates;
        int c;
        int e;
        int n;
        scan_en = 1'b1;
        wait_res(c);
        // slot end pulse stands one cycle, result follows 49 cycles after the slot end
        n = 0;
        while (conv_done !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
        tick();
        check(conv_done, 1'b0);
        repeat (48) tick();
        check(res.valid, 1'b1);
        for (int code = 7; code >= 0; code--) begin
            rate[0] = code[2:0];
            e = (code < 4) ? (int'(SDIV) * 8) >> code : (int'(FDIV) * 8) >> (code - 4);
            wait_res(c);
            check(c, e * 4);
            check(mains_rej, code <= 3);
        end
        rate = '1;
        $display("test rates done");
    endtask : t_rates

    task automatic t_scan;
        int c;
        logic [2:0] prev;
        for (int k = 0; k < NUM_SETS; k++) wr_coeff(1'b0, k[1:0], 24'(24'h00_0010 * k));
        rate[4] = 3'h6;
        raw_code = 24'h00_1000;
        first_ch = 3'h3;
        last_ch = 3'h5;
        repeat (2) wait_res(c);
        prev = res.chan;
        for (int i = 0; i < 4; i++) begin
            wait_res(c);
            check(c, (res.chan == 3'h4) ? FDIV * 8 : FDIV * 4);
            check(conv_chan, (res.chan == 3'h5) ? 3'h3 : res.chan + 3'h1);
            check(res.chan, (prev == 3'h5) ? 3'h3 : prev + 3'h1);
            check(res.data, 24'h00_1000 - 24'h00_0010 * res.chan[1:0]);
            prev = res.chan;
        end
        rate = '1;
        $display("test scan done");
    endtask : t_scan

    task automatic t_math;
        int c;
        logic [23:0] tbl [4][4] = '{
            '{24'h00_1000, 24'h00_0800, 24'h40_0000, 24'h00_1000},
            '{24'h7F_FFF0, 24'hFF_FF00, 24'h80_0000, 24'h7F_FFFF},
            '{24'h80_0010, 24'h00_0100, 24'h80_0000, 24'h80_0000},
            '{24'h00_0800, 24'h00_0800, 24'h80_0000, 24'h00_0000}};
        first_ch = 3'h0;
        last_ch = 3'h0;
        // restart the scan so every slot below converts channel 0
        scan_en = 1'b0;
        tick();
        scan_en = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wait_res(c);
            raw_code = tbl[i][0];
            wr_coeff(1'b0, 2'h0, tbl[i][1]);
            wr_coeff(1'b1, 2'h0, tbl[i][2]);
            repeat (2) wait_res(c);
            check(res.data, tbl[i][3]);
        end
        $display("test math done");
    endtask : t_math

    task automatic t_syscal;
        first_ch = 3'h1;
        last_ch = 3'h1;
        raw_code = 24'h00_0200;
        run_cal(CMD_OFFSET);
        check(offs[1], 24'h00_0200);
        wr_coeff(1'b1, 2'h1, 24'h40_0000);
        raw_code = 24'h00_0A00;
        run_cal(CMD_GAIN);
        check(gains[1], 24'h00_1000);
        $display("test syscal done");
    endtask : t_syscal

    task automatic t_bgcal;
        int c;
        int n;
        first_ch = 3'h0;
        last_ch = 3'h0;
        wr_coeff(1'b0, 2'h0, 24'h00_0000);
        wr_coeff(1'b1, 2'h0, 24'h80_0000);
        raw_code = 24'h00_1100;
        bg_mode = bg_cal_full_correct;
        fa_en = 1'b0;
        // restart on channel 0 so the measurement lands in set 0 after a cal slot
        scan_en = 1'b0;
        tick();
        scan_en = 1'b1;
        wait_res(c);
        n = 0;
        while (cal_slot !== 1'b0 && n < 2000) begin
            tick();
            n++;
        end
        bg_meas = '{valid: 1'b1, offset: 24'h00_0100, gain: 24'h40_0000};
        tick();
        bg_meas = '0;
        repeat (2) wait_res(c);
        check(c, FDIV * 8);
        check(res.data, 24'h00_0800);
        bg_mode = bg_cal_off;
        repeat (2) wait_res(c);
        check(res.data, 24'h00_1100);
        $display("test bgcal done");
    endtask : t_bgcal

    // ****************************************
    // run control
    // ****************************************
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // cycle ceiling cuts a hang short
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // main sequence
    initial begin
        repeat (5) tick();
        i_reset_n = 1'b1;
        repeat (3) tick();
        t_reset();
        t_gpio();
        t_rates();
        t_scan();
        t_math();
        t_syscal();
        t_bgcal();
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
